// File: tb/energy_mode_monitor.sv
// Purpose: Port checker for energy_mode_ctrl
// Assumes: Mode fields are mirrored from writes, since they are not ports
// Notes:   Bound to every instance
module energy_mode_monitor #(parameter DW = 16, LAW = 48, ZCW = 16) (
  input logic                  clk,
  input logic                  rst_n,
  input logic [7:0]            reg_addr,
  input logic [7:0]            reg_wdata,
  input logic                  reg_we,
  input logic                  reg_re,
  input logic [7:0]            reg_rdata,
  input logic signed [DW-1:0]  waveform_sample,
  input logic                  sample_valid,
  input logic signed [2*DW+2:0] active_power,
  input logic signed [LAW-1:0] line_active_energy_accumulator,
  input logic [2:0]            negative_power,
  input logic [2:0]            zero_cross_phase_select,
  input logic [ZCW-1:0]        zero_cross_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // Register mirror
  logic [7:0] w_q, m_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_q <= 8'h00;
      m_q <= 8'h3f;
    end else if (reg_we && reg_addr == 8'h0c) w_q <= reg_wdata;
    else if (reg_we && reg_addr == 8'h0d) m_q <= reg_wdata;
  end
  property p_src_rsv; sample_valid && $past(w_q[2:1]) == 2'b11 |-> waveform_sample == 0; endproperty
  a_src_rsv: assert property (p_src_rsv) else $error("reserved source not zero");
  property p_valid; sample_valid |=> !sample_valid [*8]; endproperty
  a_valid: assert property (p_valid) else $error("samples too close");
  property p_line; sample_valid && $past(m_q[2:0]) == 3'h0 && !$past(w_q[5])
    |-> $stable(line_active_energy_accumulator); endproperty
  a_line: assert property (p_line) else $error("line sum moved with no terms");
  property p_terms; sample_valid && $past(m_q[5:3]) == 3'h0 |-> active_power == 0; endproperty
  a_terms: assert property (p_terms) else $error("power with no terms");
  property p_neg; (negative_power & ~$past(m_q[5:3])) == 3'h0; endproperty
  a_neg: assert property (p_neg) else $error("negative flag on disabled phase");
  property p_form; sample_valid && $past(m_q[7:6]) == 2'h3 |-> active_power == 0; endproperty
  a_form: assert property (p_form) else $error("reserved formula not zero");
  property p_rd; reg_re && reg_addr == 8'h0d |=> reg_rdata == $past(m_q); endproperty
  a_rd: assert property (p_rd) else $error("mode readback wrong");
  property p_zc; zero_cross_phase_select == 3'h0 |=> $stable(zero_cross_count); endproperty
  a_zc: assert property (p_zc) else $error("count moved with no phase");
endmodule
bind energy_mode_ctrl energy_mode_monitor #(.DW(DW), .LAW(LAW), .ZCW(ZCW)) u_mon (.*);

// File: tb/host_model.sv
// Purpose: Host side of the register strobe port
// Assumes: Strobes change at the falling edge
// Notes:   Reserved codes only when the caller insists
module host_model (
  input  logic       clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_we,
  output logic       reg_re,
  input  logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wdata, reg_we, reg_re} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rsv = 0);
    if (!rsv && (a == 8'h0c && d[2:1] == 2'b11 || a == 8'h0d && d[7:6] == 2'b11)) return;
    @(negedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(negedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(negedge clk);
    reg_re <= 1'b0;
    d = reg_rdata;
  endtask
endmodule

// File: tb/waveform_and_active_energy_mode_config_tb.sv
// Purpose: Scenario bench for energy_mode_ctrl
// Assumes: Constant phase samples, rate 0 for power checks
// Notes:   Expected sums come from the formula table
module waveform_and_active_energy_mode_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, reg_we, reg_re, sample_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [2:0] zero_cross, zero_cross_phase_select, negative_power;
  logic [15:0] zero_cross_count;
  logic signed [15:0] waveform_sample;
  logic signed [34:0] active_power, lr;
  logic signed [47:0] acc;
  logic signed [15:0] smp [6] = '{16'h0005, 16'h0006, 16'h0007, 16'hfffd, 16'h0004, 16'h0002};
  logic [2:0] tsel [4] = '{3'h7, 3'h5, 3'h2, 3'h0};
  int error_cnt = 0, n_checks = 0;
  energy_mode_ctrl DUT (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .volt_a(smp[0]), .volt_b(smp[1]), .volt_c(smp[2]), .curr_a(smp[3]), .curr_b(smp[4]),
    .curr_c(smp[5]), .line_reactive_in(lr), .zero_cross, .zero_cross_phase_select,
    .waveform_sample, .sample_valid, .active_power, .line_active_energy_accumulator(acc),
    .negative_power, .zero_cross_count);
  host_model host (.clk, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  // ====
  // Helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Bound is far above the longest sample gap, 3072 cycles at rate 3; a rate drop ticks at once when the count is already past the new limit
  task automatic wait_v;
    int n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!sample_valid && n < 9000);
    if (n >= 9000) begin
      chk(0, 1);
      tally_and_finish;
    end
  endtask
  task automatic t_reset;
    logic [7:0] d;
    host.rd(8'h0c, d);
    chk(d, 8'h00);
    host.rd(8'h0d, d);
    chk(d, 8'h3f);
    host.rd(8'h20, d);
    chk(d, 8'h00);
  endtask
  task automatic t_rate;
    int n;
    for (int r = 0; r < 4; r++) begin
      host.wr(8'h0c, 8'(r << 3));
      wait_v;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!sample_valid && n < 4000);
      chk(n, 384 << r);
      chk(waveform_sample, smp[0]);
    end
  endtask
  task automatic t_mode(input logic [1:0] f, input logic [2:0] t, input logic [2:0] s, bit lv);
    longint a, b, c, p;
    logic signed [47:0] acc0;
    host.wr(8'h0c, {2'b00, lv, 2'b00, s}, 1);
    host.wr(8'h0d, {f, t, t}, 1);
    wait_v;
    wait_v;
    acc0 = acc;
    wait_v;
    a = f == 3 ? 0 : smp[0] * (f == 0 ? smp[3] : smp[3] - smp[4]);
    b = f == 0 ? smp[1] * smp[4] : 0;
    c = f == 3 ? 0 : smp[2] * (f == 1 ? smp[5] - smp[4] : smp[5]);
    p = (t[2] ? a : 0) + (t[1] ? b : 0) + (t[0] ? c : 0);
    chk(active_power, p);
    chk(negative_power, {t[2] && a < 0, t[1] && b < 0, t[0] && c < 0});
    chk(waveform_sample, s > 5 ? 0 : smp[s]);
    chk(acc - acc0, lv ? lr : p);
  endtask
  task automatic t_zc;
    logic [15:0] z0;
    for (int k = 0; k < 2; k++) begin
      zero_cross_phase_select = k ? 3'h0 : 3'h5;
      z0 = zero_cross_count;
      zero_cross = 3'h7;
      @(negedge clk);
      zero_cross = 3'h0;
      @(negedge clk);
      chk(16'(zero_cross_count - z0), k ? 0 : 2);
    end
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_n = 0;
    lr = 35'h0000_0010;
    zero_cross = 3'h0;
    zero_cross_phase_select = 3'h7;
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_reset;
    t_rate;
    for (int i = 0; i < 16; i++) t_mode(2'(i / 4), tsel[i % 4], 3'(i % 7), i == 5);
    t_zc;
    tally_and_finish;
  end
endmodule

// File: verilog/energy_mode_ctrl.v
// Purpose: Waveform sampling and active energy mode registers with their datapath
// Assumes: Register port driven by the serial interface decoder on clk
// Notes:   Phase samples and zero-crossing pulses come from logic on clk
`include "energy_mode_regs.vh"
module energy_mode_ctrl #(
  parameter DW  = 16,
  parameter LAW = 48,
  parameter ZCW = 16
) (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire [7:0]              reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_we,
  input  wire                    reg_re,
  output reg  [7:0]              reg_rdata,
  input  wire signed [DW-1:0]    volt_a,
  input  wire signed [DW-1:0]    volt_b,
  input  wire signed [DW-1:0]    volt_c,
  input  wire signed [DW-1:0]    curr_a,
  input  wire signed [DW-1:0]    curr_b,
  input  wire signed [DW-1:0]    curr_c,
  input  wire signed [2*DW+2:0]  line_reactive_in,
  input  wire [2:0]              zero_cross,
  input  wire [2:0]              zero_cross_phase_select,
  output reg  signed [DW-1:0]    waveform_sample,
  output reg                     sample_valid,
  output reg  signed [2*DW+2:0]  active_power,
  output reg  signed [LAW-1:0]   line_active_energy_accumulator,
  output reg  [2:0]              negative_power,
  output reg  [ZCW-1:0]          zero_cross_count
);
  localparam PW = 2 * DW + 1;
  localparam SW = PW + 2;

  reg  [7:0]             wsm_q;
  reg  [7:0]             aem_q;
  reg  [`RATE_CNT_W-1:0] div_q;
  wire [2:0]             src;
  wire [1:0]             rate;
  wire                   lvar_sel;
  wire [2:0]             lterm;
  wire [2:0]             term;
  wire [1:0]             form;
  wire [`RATE_CNT_W-1:0] div_limit;
  wire                   tick;
  wire signed [PW-1:0]   raw_a;
  wire signed [PW-1:0]   raw_b;
  wire signed [PW-1:0]   raw_c;
  reg  signed [PW-1:0]   t_a;
  reg  signed [PW-1:0]   t_b;
  reg  signed [PW-1:0]   t_c;
  reg  signed [SW-1:0]   sum_act;
  reg  signed [SW-1:0]   sum_line;
  reg  signed [SW-1:0]   line_in;
  reg  signed [DW-1:0]   sel_sample;
  reg  [1:0]             zc_hits;
  wire                   wr_wsm;
  wire                   wr_aem;
  wire signed [SW-1:0]   ext_a;
  wire signed [SW-1:0]   ext_b;
  wire signed [SW-1:0]   ext_c;
  reg  signed [SW-1:0]   act_a;
  reg  signed [SW-1:0]   act_b;
  reg  signed [SW-1:0]   act_c;
  reg  signed [SW-1:0]   lin_a;
  reg  signed [SW-1:0]   lin_b;
  reg  signed [SW-1:0]   lin_c;
  reg  [1:0]             zc_a;
  reg  [1:0]             zc_b;
  reg  [1:0]             zc_c;

  assign src      = wsm_q[`SRC_MSB:`SRC_LSB];
  assign rate     = wsm_q[`RATE_MSB:`RATE_LSB];
  assign lvar_sel = wsm_q[`LVAR_BIT];
  assign lterm    = aem_q[`LTERM_MSB:`LTERM_LSB];
  assign term     = aem_q[`TERM_MSB:`TERM_LSB];
  assign form     = aem_q[`FORM_MSB:`FORM_LSB];
  assign wr_wsm   = reg_we && (reg_addr == `WSM_ADDR);
  assign wr_aem   = reg_we && (reg_addr == `AEM_ADDR);

  // ============================================================
  // Register port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wsm_q     <= `WSM_RST;
      aem_q     <= `AEM_RST;
      reg_rdata <= `RDATA_IDLE;
    end else begin
      // Reserved codes are stored as written; the host keeps clear of them
      if (wr_wsm) begin
        wsm_q <= reg_wdata;
      end
      if (wr_aem) begin
        aem_q <= reg_wdata;
      end
      // Same-cycle read returns the value from before the write
      if (reg_re) begin
        case (reg_addr)
          `WSM_ADDR: reg_rdata <= wsm_q;
          `AEM_ADDR: reg_rdata <= aem_q;
          default:   reg_rdata <= `RDATA_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // Sample rate divider
  // Divide by 3 and by 128 << rate folded into one counter
  assign div_limit = `RATE_BASE << rate;
  assign tick      = (div_q >= div_limit - 1'b1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= {`RATE_CNT_W{1'b0}};
    end else if (tick) begin
      div_q <= {`RATE_CNT_W{1'b0}};
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // ============================================================
  // Waveform sample source
  always @* begin
    case (src)
      `SRC_VA: sel_sample = volt_a;
      `SRC_VB: sel_sample = volt_b;
      `SRC_VC: sel_sample = volt_c;
      `SRC_IA: sel_sample = curr_a;
      `SRC_IB: sel_sample = curr_b;
      `SRC_IC: sel_sample = curr_c;
      default: sel_sample = {DW{1'b0}};
    endcase
  end

  // ============================================================
  // Active energy terms
  // Phase B current is subtracted only in the two-wattmeter formulas
  phase_term #(.DW(DW)) u_term_a (
    .v      (volt_a),
    .i      (curr_a),
    .isub   (curr_b),
    .sub_en (form == `FORM_DELTA2 || form == `FORM_DELTA1),
    .prod   (raw_a)
  );

  phase_term #(.DW(DW)) u_term_b (
    .v      (volt_b),
    .i      (curr_b),
    .isub   (curr_b),
    .sub_en (1'b0),
    .prod   (raw_b)
  );

  phase_term #(.DW(DW)) u_term_c (
    .v      (volt_c),
    .i      (curr_c),
    .isub   (curr_b),
    .sub_en (form == `FORM_DELTA2),
    .prod   (raw_c)
  );

  always @* begin
    // Reserved formula yields zero rather than a guessed formula
    t_a = (form == `FORM_RSV) ? {PW{1'b0}} : raw_a;
    t_b = (form == `FORM_STAR) ? raw_b : {PW{1'b0}};
    t_c = (form == `FORM_RSV) ? {PW{1'b0}} : raw_c;
  end

  // Two guard bits so three full-scale terms cannot wrap the sum
  assign ext_a = {{2{t_a[PW-1]}}, t_a};
  assign ext_b = {{2{t_b[PW-1]}}, t_b};
  assign ext_c = {{2{t_c[PW-1]}}, t_c};

  // ============================================================
  // Term gating
  always @* begin
    act_a   = term[2] ? ext_a : {SW{1'b0}};
    act_b   = term[1] ? ext_b : {SW{1'b0}};
    act_c   = term[0] ? ext_c : {SW{1'b0}};
    sum_act = act_a + act_b + act_c;
  end

  always @* begin
    lin_a    = lterm[2] ? ext_a : {SW{1'b0}};
    lin_b    = lterm[1] ? ext_b : {SW{1'b0}};
    lin_c    = lterm[0] ? ext_c : {SW{1'b0}};
    sum_line = lin_a + lin_b + lin_c;
    line_in  = lvar_sel ? line_reactive_in : sum_line;
  end

  always @* begin
    zc_a    = {1'b0, zero_cross[0] & zero_cross_phase_select[0]};
    zc_b    = {1'b0, zero_cross[1] & zero_cross_phase_select[1]};
    zc_c    = {1'b0, zero_cross[2] & zero_cross_phase_select[2]};
    zc_hits = zc_a + zc_b + zc_c;
  end

  // ============================================================
  // Outputs and accumulation
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waveform_sample                <= {DW{1'b0}};
      sample_valid                   <= 1'b0;
      active_power                   <= {SW{1'b0}};
      line_active_energy_accumulator <= {LAW{1'b0}};
    end else begin
      sample_valid <= tick;
      if (tick) begin
        waveform_sample <= sel_sample;
        active_power    <= sum_act;
        line_active_energy_accumulator <= line_active_energy_accumulator
          + {{(LAW-SW){line_in[SW-1]}}, line_in};
      end
    end
  end

  // ============================================================
  // Negative power detection
  // Follows the same enables as the energy terms, updated every cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      negative_power <= 3'h0;
    end else begin
      negative_power <= term & {t_a[PW-1], t_b[PW-1], t_c[PW-1]};
    end
  end

  // ============================================================
  // Zero-crossing count
  // Counts on every cycle, independent of the sample tick, and wraps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_cross_count <= {ZCW{1'b0}};
    end else begin
      zero_cross_count <= zero_cross_count + {{(ZCW-2){1'b0}}, zc_hits};
    end
  end
endmodule

// File: verilog/energy_mode_regs.vh
// Purpose: Constants for the waveform and active energy mode registers
// Assumes: 8-bit registers reached through the device's serial register port
// Notes:   Field positions, codes and counts shared by both registers
// Operation
// - Sample source codes pick voltage or current phase
// - Rate field divides clock by 3, then 128..1024
// - Line reactive bit routes reactive energy to accumulator
// - Line term bits gate line active formula terms
// - Term enable bits gate active formula terms
// - Term enables also gate per-phase negative detection
// - Formula field chooses three-phase active energy formula
// - Any term enable combination is accepted
// - Zero crossings counted only on selected phases
`ifndef ENERGY_MODE_REGS_VH
`define ENERGY_MODE_REGS_VH

// ============================================================
// Register offsets
`define WSM_ADDR       8'h0c
`define AEM_ADDR       8'h0d

// ============================================================
// Reset values
`define WSM_RST        8'h00
`define AEM_RST        8'h3f

// ============================================================
// Waveform sampling mode fields
`define SRC_LSB        0
`define SRC_MSB        2
`define RATE_LSB       3
`define RATE_MSB       4
`define LVAR_BIT       5

// ============================================================
// Active energy mode fields
`define LTERM_LSB      0
`define LTERM_MSB      2
`define TERM_LSB       3
`define TERM_MSB       5
`define FORM_LSB       6
`define FORM_MSB       7

// ============================================================
// Sample source codes
`define SRC_VA         3'h0
`define SRC_VB         3'h1
`define SRC_VC         3'h2
`define SRC_IA         3'h3
`define SRC_IB         3'h4
`define SRC_IC         3'h5

// ============================================================
// Formula codes
`define FORM_STAR      2'h0
`define FORM_DELTA2    2'h1
`define FORM_DELTA1    2'h2
`define FORM_RSV       2'h3

// ============================================================
// Read data for unmapped addresses and after reset
`define RDATA_IDLE     8'h00

// ============================================================
// Rate divider: three times the smallest divide, shifted by the rate code
`define RATE_BASE      12'h180
`define RATE_CNT_W     12

`endif

// File: verilog/phase_term.v
// Purpose: One phase term of the active energy formula, v * (i - optional isub)
// Assumes: Signed samples on the same clock as the caller
// Notes:   Purely combinational; the caller registers the result
module phase_term #(
  parameter DW = 16
) (
  input  wire signed [DW-1:0]   v,
  input  wire signed [DW-1:0]   i,
  input  wire signed [DW-1:0]   isub,
  input  wire                   sub_en,
  output wire signed [2*DW:0]   prod
);
  wire signed [DW:0] diff;

  // Difference kept one bit wider so full-scale opposite currents cannot wrap
  assign diff = {i[DW-1], i} - (sub_en ? {isub[DW-1], isub} : {(DW+1){1'b0}});
  assign prod = v * diff;
endmodule
